// File: sac_consts.vh
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// Register byte addresses
`define SAC_A_CTRL   8'h00
`define SAC_A_CFG    8'h04
`define SAC_A_RESULT 8'h08
`define SAC_A_STATUS 8'h0C
`define SAC_A_MASK   8'h10
`define SAC_A_STATE  8'h14

// Control register fields
`define SAC_C_START  0
`define SAC_C_TRACK  1
`define SAC_C_LJST   2
`define SAC_C_TM_LO  3
`define SAC_C_TM_HI  4
`define SAC_C_BURST  5
`define SAC_C_EXTEN  6
`define SAC_C_WMASK  8'h7E

// Config register fields
`define SAC_F_DIV_LO 0
`define SAC_F_DIV_HI 4
`define SAC_F_RPT_LO 6
`define SAC_F_RPT_HI 7
`define SAC_F_TK_LO  8
`define SAC_F_TK_HI  11

// Status and mask bits
`define SAC_S_DONE   0
`define SAC_S_EXT    1

// Reset values
`define SAC_RST_CTRL 8'h00
`define SAC_RST_CFG  12'h004
`define SAC_RST_MASK 2'h0

// Tracking mode codes
`define SAC_TM_PRE   2'h0
`define SAC_TM_POST  2'h1
`define SAC_TM_DUAL  2'h3

// Repeat count codes
`define SAC_RPT_1    2'h0
`define SAC_RPT_4    2'h1
`define SAC_RPT_8    2'h2
`define SAC_RPT_16   2'h3

// Conversion step counts
`define SAC_TK_EXTRA   5'h02
`define SAC_STEP_START 4'h0
`define SAC_STEP_SAR1  4'h1
`define SAC_STEP_LAST  4'hD
`define SAC_STEP_DONE  4'hE
`define SAC_TRIAL_MSB  12'h800
`define SAC_RES_BITS   4'hC

`endif

// File: sac_sequencer.v
// How it works
// - Mode 01b: tracking interval starts at convert start, conversion follows.
// - Post-tracking: input stays disconnected after conversion until next start.
// - Mode 11b: timed tracking, convert, then track continuously until next.
// - Subsystem clock is core clock or burst oscillator by select bit.
// - SAR clock is subsystem clock divided by the divider field plus one.
// - Sequencer is always in exactly one of tracking, converting, idle.
// - Pre-tracking: software tracks, conversion starts at once on start.
// - Timed tracking lasts setting plus two subsystem clock cycles.
// - Conversion is 13 SAR cycles plus two subsystem clock cycles.
// - Repeat one: 12-bit unsigned result, updated each conversion.
// - Left justify bit picks alignment: 0x0FFF or 0xFFF0 full scale.
// - Unused result bits read as zero.
// - Repeat above one: sum of series, updated after last conversion.
// - Repeat select allows series of 4, 8 or 16 samples.
// - External pin can also request a convert start.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`include "sac_consts.vh"

module sac_sequencer (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rst_in,
  // Avalon-MM slave
  input  wire [7:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  // Interrupt
  output wire        irq_out,
  // Pins and analog front end
  input  wire        external_convert_start_in,
  input  wire        burst_osc_in,
  input  wire        comparator_in,
  output reg         sample_connect_out,
  output reg         sar_clk_out,
  output reg  [11:0] sar_trial_out,
  output reg  [1:0]  state_out
);

  // Sequencer states
  // Code 3 is never entered; the default arm returns it to idle
  localparam ST_IDLE  = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV  = 2'h2;

  // Last sample index of a series
  // A repeat code of one makes every sample the last
  function [3:0] rpt_last;
    input [1:0] sel;
    begin
      case (sel)
        `SAC_RPT_4:  rpt_last = 4'h3;
        `SAC_RPT_8:  rpt_last = 4'h7;
        `SAC_RPT_16: rpt_last = 4'hF;
        default:     rpt_last = 4'h0;
      endcase
    end
  endfunction

  // Register select; one compare shared by write strobes and read mux
  function reg_hit;
    input [7:0] addr;
    input [7:0] base;
    begin
      reg_hit = (addr == base);
    end
  endfunction

  // Software registers
  reg  [7:0]  ctrl;
  reg  [11:0] cfg;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [15:0] result;

  // Bus handshake
  reg         ack;

  // Synchronisers
  reg  [2:0]  bsync;
  reg  [2:0]  esync;
  reg  [1:0]  csync;

  // Sequencer
  reg  [1:0]  state;
  reg         pend;
  reg  [4:0]  trk_cnt;
  reg  [3:0]  step;
  reg  [4:0]  div_cnt;
  reg  [15:0] acc;
  reg  [3:0]  smp_cnt;
  reg         done_pulse;

  // Combinational helpers
  reg  [11:0] next_code;
  reg  [31:0] next_rdata;
  reg         next_connect;

  // Field views
  // Tracking setting is four bits, so the interval runs 2 to 17 ticks
  wire [1:0]  tm    = ctrl[`SAC_C_TM_HI:`SAC_C_TM_LO];
  wire        ljst  = ctrl[`SAC_C_LJST];
  wire        burst = ctrl[`SAC_C_BURST];
  wire [4:0]  div   = cfg[`SAC_F_DIV_HI:`SAC_F_DIV_LO];
  wire [1:0]  rpt   = cfg[`SAC_F_RPT_HI:`SAC_F_RPT_LO];
  wire [3:0]  tk    = cfg[`SAC_F_TK_HI:`SAC_F_TK_LO];

  // Bus strobes: one wait state, then the access completes
  // Waitrequest is combinational so an idle bus never stalls
  wire        req   = avs_read_in | avs_write_in;
  wire        wr_go = avs_write_in & ack;
  wire        rd_go = avs_read_in & ack;
  assign avs_waitrequest_out = req & ~ack;

  wire        wr_ctrl = wr_go && reg_hit(avs_address_in, `SAC_A_CTRL);
  wire        wr_cfg  = wr_go && reg_hit(avs_address_in, `SAC_A_CFG);
  wire        wr_mask = wr_go && reg_hit(avs_address_in, `SAC_A_MASK);
  wire        rd_stat = rd_go && reg_hit(avs_address_in, `SAC_A_STATUS);

  // Clear only bits that the read returned; a later event survives
  wire [1:0]  rd_clr  = avs_readdata_out[1:0] & {2{rd_stat}};

  // Subsystem clock tick; burst oscillator edge seen after sync
  // Burst ticks come once per oscillator period, far slower than the core
  wire        burst_rise = bsync[1] & ~bsync[2];
  wire        converter_subsystem_clock_tick  = burst ? burst_rise : 1'b1;

  // External start edge, only after two flops
  // Held pin levels start nothing; only a fresh rising edge counts
  wire        ext_rise = esync[1] & ~esync[2] & ctrl[`SAC_C_EXTEN];
  wire        sw_start = wr_ctrl & avs_writedata_in[`SAC_C_START];
  wire        start_req = sw_start | ext_rise;

  // Start taken on a subsystem tick while idle
  // In burst mode a start may wait several core cycles here
  wire        take = converter_subsystem_clock_tick & (state == ST_IDLE) & pend;

  // SAR clock edge at the end of each divided period
  wire        sar_phase = (state == ST_CONV) && (step != `SAC_STEP_START) &&
                          (step != `SAC_STEP_DONE);
  wire        sar_tick  = converter_subsystem_clock_tick & sar_phase & (div_cnt == div);

  // Bit under test during SAR steps
  wire [3:0]  bit_idx  = `SAC_STEP_LAST - step;
  wire [3:0]  bit_next = bit_idx - 4'h1;

  // Series arithmetic, 16 bits so sixteen 12-bit samples fit
  // Left justify is ignored for sums; software keeps it clear
  wire [15:0] sum       = acc + {4'h0, sar_trial_out};
  wire        last_smp  = smp_cnt >= rpt_last(rpt);
  wire [15:0] aligned   = ljst ? {sar_trial_out, 4'h0}
                               : {4'h0, sar_trial_out};

  // Level interrupt from any unmasked sticky bit
  assign irq_out = |(status & mask);

  // Bus acknowledge: pulse one cycle after the request appears
  // Fixed single wait state keeps read data a registered output
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Read mux; unmapped addresses read zero
  // Reads have no side effect here; status clear happens on the ack edge
  always @* begin
    next_rdata = 32'h0000_0000;
    if (reg_hit(avs_address_in, `SAC_A_CTRL)) begin
      next_rdata[7:0] = ctrl;
    end else if (reg_hit(avs_address_in, `SAC_A_CFG)) begin
      next_rdata[11:0] = cfg;
    end else if (reg_hit(avs_address_in, `SAC_A_RESULT)) begin
      next_rdata[15:0] = result;
    end else if (reg_hit(avs_address_in, `SAC_A_STATUS)) begin
      next_rdata[1:0] = status;
    end else if (reg_hit(avs_address_in, `SAC_A_MASK)) begin
      next_rdata[1:0] = mask;
    end else if (reg_hit(avs_address_in, `SAC_A_STATE)) begin
      next_rdata[2:0] = {pend, state};
    end
  end

  // Read data registered so it stands when waitrequest drops
  // Captured on the first request cycle; status clear uses this copy
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in & ~ack) begin
      avs_readdata_out <= next_rdata;
    end
  end

  // Software registers; start bit never stored, it only pulses
  // Config is taken whole; a rewrite mid-conversion applies at once
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl <= `SAC_RST_CTRL;
      cfg  <= `SAC_RST_CFG;
      mask <= `SAC_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        ctrl <= avs_writedata_in[7:0] & `SAC_C_WMASK;
      end
      if (wr_cfg) begin
        cfg <= avs_writedata_in[11:0];
      end
      if (wr_mask) begin
        mask <= avs_writedata_in[1:0];
      end
    end
  end

  // Sticky status; a new event beats the clear-on-read
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= 2'h0;
    end else begin
      status <= (status & ~rd_clr) |
                {ext_rise, done_pulse};
    end
  end

  // Two-flop synchronisers; third flop only for edge detection
  // Logic reads only the second and third flops, never the metastable first
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bsync <= 3'h0;
      esync <= 3'h0;
      csync <= 2'h0;
    end else begin
      bsync <= {bsync[1:0], burst_osc_in};
      esync <= {esync[1:0], external_convert_start_in};
      csync <= {csync[0], comparator_in};
    end
  end

  // Next SAR trial word
  // Comparator arrives two cycles late; divider of two or more covers it
  // Steps outside the SAR window leave the word untouched
  always @* begin
    next_code = sar_trial_out;
    if (step == `SAC_STEP_SAR1) begin
      next_code = `SAC_TRIAL_MSB;
    end else if (bit_idx < `SAC_RES_BITS) begin
      next_code[bit_idx] = csync[1];
      if (bit_idx != 4'h0) begin
        next_code[bit_next] = 1'b1;
      end
    end
  end

  // Pending start; starts while busy are dropped
  // Not queued: a start during a conversion would upset the series count
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend <= 1'b0;
    end else begin
      pend <= (pend & ~take) |
              (start_req & (state == ST_IDLE) & ~take);
    end
  end

  // Main sequencer; only one state code is ever held
  // Step 0 is the start tick, 1 to 13 are SAR periods, 14 the finish tick
  // Every counter advances only on a subsystem tick, so burst mode
  // stretches the whole sequence without changing any count
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state         <= ST_IDLE;
      trk_cnt       <= 5'h00;
      step          <= `SAC_STEP_START;
      div_cnt       <= 5'h00;
      sar_trial_out <= 12'h000;
      acc           <= 16'h0000;
      smp_cnt       <= 4'h0;
      result        <= 16'h0000;
      done_pulse    <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      if (converter_subsystem_clock_tick) begin
        case (state)
          ST_IDLE: begin
            if (pend) begin
              if (tm == `SAC_TM_POST || tm == `SAC_TM_DUAL) begin
                state   <= ST_TRACK;
                trk_cnt <= 5'h00;
              end else begin
                state <= ST_CONV;
                step  <= `SAC_STEP_START;
              end
            end
          end
          ST_TRACK: begin
            if (trk_cnt == {1'b0, tk} + `SAC_TK_EXTRA - 5'h01) begin
              state <= ST_CONV;
              step  <= `SAC_STEP_START;
            end else begin
              trk_cnt <= trk_cnt + 5'h01;
            end
          end
          ST_CONV: begin
            if (step == `SAC_STEP_START) begin
              step    <= `SAC_STEP_SAR1;
              div_cnt <= 5'h00;
            end else if (step == `SAC_STEP_DONE) begin
              state <= ST_IDLE;
              if (last_smp) begin
                result     <= (rpt == `SAC_RPT_1) ? aligned : sum;
                done_pulse <= 1'b1;
                acc        <= 16'h0000;
                smp_cnt    <= 4'h0;
              end else begin
                acc     <= sum;
                smp_cnt <= smp_cnt + 4'h1;
              end
            end else if (sar_tick) begin
              div_cnt       <= 5'h00;
              sar_trial_out <= next_code;
              step          <= step + 4'h1;
            end else begin
              div_cnt <= div_cnt + 5'h01;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Sampling switch per mode; idle behaviour differs by mode
  // Post mode leaves the input floating between conversions
  always @* begin
    next_connect = 1'b0;
    case (state)
      ST_TRACK: next_connect = 1'b1;
      ST_CONV:  next_connect = 1'b0;
      default: begin
        if (tm == `SAC_TM_POST) begin
          next_connect = 1'b0;
        end else if (tm == `SAC_TM_DUAL) begin
          next_connect = 1'b1;
        end else begin
          next_connect = ctrl[`SAC_C_TRACK];
        end
      end
    endcase
  end

  // Registered pin outputs
  // State pin lags the sequencer by one cycle
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_connect_out <= 1'b0;
      sar_clk_out        <= 1'b0;
      state_out          <= ST_IDLE;
    end else begin
      sample_connect_out <= next_connect;
      sar_clk_out        <= sar_phase && (div_cnt <= {1'b0, div[4:1]});
      state_out          <= state;
    end
  end

endmodule // sac_sequencer

// File: sac_front_end.sv
module sac_front_end (
  // Analog level and trial code
  input  wire logic [11:0] level_in,
  input  wire logic [11:0] trial_in,
  // Comparator decision
  output logic             comparator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Ideal comparator, no offset, so every code is exact
  assign comparator_out = (level_in >= trial_in);
endmodule // sac_front_end

// File: sac_sequencer_monitor.sv
module sac_sequencer_monitor (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // Bus and outputs
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        irq_out,
  input wire logic        sar_clk_out,
  input wire logic        sample_connect_out,
  input wire logic [1:0]  state_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Request and minimum conversion span
  sequence s_req; avs_read_in || avs_write_in; endsequence
  sequence s_conv8; (state_out == 2'h2) [*8]; endsequence
  property p_state_ok; state_out != 2'h3; endproperty
  a_state_ok: assert property (p_state_ok) else $error("illegal state code");
  property p_conv_hold; $rose(state_out == 2'h2) |-> s_conv8; endproperty
  a_conv_hold: assert property (p_conv_hold) else $error("conversion too short");
  property p_track_hold; $rose(state_out == 2'h1) |-> (state_out == 2'h1) [*2]; endproperty
  a_track_hold: assert property (p_track_hold) else $error("tracking under two ticks");
  property p_sar_conv; sar_clk_out |-> state_out == 2'h2 || $past(state_out) == 2'h2; endproperty
  a_sar_conv: assert property (p_sar_conv) else $error("sar clock outside conversion");
  property p_wait_one; s_req ##0 avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_idle_go; !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out; endproperty
  a_idle_go: assert property (p_idle_go) else $error("wait without request");
  property p_irq_fall; $fell(irq_out) |-> $past(avs_read_in || avs_write_in); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
  property p_rd_hold; $changed(avs_readdata_out) |-> $past(avs_read_in); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_track_conn; state_out == 2'h1 |-> sample_connect_out; endproperty
  a_track_conn: assert property (p_track_conn) else $error("input open while tracking");
  property p_conv_open; state_out == 2'h2 |-> !sample_connect_out; endproperty
  a_conv_open: assert property (p_conv_open) else $error("input connected while converting");
endmodule // sac_sequencer_monitor

bind sac_sequencer sac_sequencer_monitor u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out), .sar_clk_out(sar_clk_out),
  .sample_connect_out(sample_connect_out), .state_out(state_out));

// File: sac_sequencer_test.sv
module sac_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, ext, burst, comp, conn, sclk, irq, wreq;
  logic [7:0]  addr;
  logic [31:0] wd, rdat, q;
  logic [11:0] level, trial;
  logic [1:0]  st;
  int          failures, checks, tc, cc;
  sac_sequencer u_dut (.core_clk_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .irq_out(irq), .external_convert_start_in(ext), .burst_osc_in(burst), .comparator_in(comp),
    .sample_connect_out(conn), .sar_clk_out(sclk), .sar_trial_out(trial), .state_out(st));
  sac_front_end u_fe (.level_in(level), .trial_in(trial), .comparator_out(comp));
  // Core clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Burst oscillator runs free, unrelated to the core clock
  initial begin
    burst = 1'b0;
    forever #61 burst = ~burst;
  end
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // One bus access; holds the request until waitrequest is low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0) failures++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  // Start by register or by pin, counting tracking and converting cycles
  task automatic conv(input logic [7:0] c);
    bit seen;
    seen = 0;
    tc = 0;
    cc = 0;
    bus(1'b1, 8'h00, {24'h0, c | {7'h0, !c[6]}});
    for (int n = 0; n < 4000 && !(seen && st != 2'h2); n++) begin
      @(posedge clk);
      ext <= c[6] && n < 4;
      tc += int'(st == 2'h1);
      cc += int'(st == 2'h2);
      seen |= (st == 2'h2);
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic row(input logic [7:0] c, input logic [11:0] f, l, input logic [15:0] r, input int t,
                     input logic [1:0] s, input logic k);
    level <= l;
    bus(1'b1, 8'h04, {20'h0, f});
    conv(c);
    if (c[5]) chk("burst span", 1, cc > 150);
    else begin
      chk("track cycles", t, tc);
      chk("conv cycles", 41, cc);
    end
    chk("irq set", 1, irq);
    rdchk("status", 8'h0C, {30'h0, s});
    @(negedge clk);
    chk("irq clear", 0, irq);
    rdchk("result", 8'h08, {16'h0, r});
    chk("connect", k, conn);
    $display("row ctrl %h done", c);
  endtask
  // Main sequence
  initial begin
    {rst, rd, wr, ext, addr, wd, level, failures, checks} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdchk("ctrl reset", 8'h00, 32'h0);
    rdchk("cfg reset", 8'h04, 32'h4);
    rdchk("mask reset", 8'h10, 32'h0);
    bus(1'b1, 8'h18, 32'hFFFF);
    rdchk("unmapped", 8'h18, 32'h0);
    bus(1'b1, 8'h10, 32'h3);
    $display("reset test done");
    row(8'h00, 12'h002, 12'hFFF, 16'h0FFF, 0, 2'h1, 1'b0);
    row(8'h04, 12'h002, 12'h7FF, 16'h7FF0, 0, 2'h1, 1'b0);
    row(8'h08, 12'h302, 12'h800, 16'h0800, 5, 2'h1, 1'b0);
    row(8'h40, 12'h002, 12'h000, 16'h0000, 0, 2'h3, 1'b0);
    row(8'h18, 12'h302, 12'h001, 16'h0001, 5, 2'h1, 1'b1);
    row(8'h28, 12'h302, 12'hABC, 16'h0ABC, 0, 2'h1, 1'b0);
    for (int r = 1; r < 4; r++) begin
      level <= 12'hFFF;
      bus(1'b1, 8'h04, 32'h002 | (r << 6));
      for (int k = 0; k < (2 << r); k++) begin
        conv(8'h00);
        if (k == 0) chk("mid series irq", 0, irq);
      end
      rdchk("series status", 8'h0C, 32'h1);
      rdchk("series sum", 8'h08, 32'hFFF << (r + 1));
      $display("repeat series %0d done", r);
    end
    bus(1'b1, 8'h04, 32'h002);
    bus(1'b1, 8'h10, 32'h0);
    conv(8'h00);
    chk("masked irq", 0, irq);
    bus(1'b1, 8'h10, 32'h1);
    @(negedge clk);
    chk("unmasked irq", 1, irq);
    rdchk("masked status", 8'h0C, 32'h1);
    $display("mask test done");
    results;
  end
  // Watchdog against a hang
  initial begin
    #500000;
    failures++;
    results;
  end
endmodule // sac_sequencer_test
